/* File: rtl/umc_pkg.sv */
// Package for the serial-port mode control and prescaler block.
// Assumes a single 250 MHz clock domain and word-wide register access.
package umc_pkg;
    localparam logic [7:0]  MODE_CTRL_OFFSET   = 8'h14;
    localparam logic [7:0]  GUARD_PSC_OFFSET   = 8'h18;
    localparam logic [31:0] MODE_CTRL_RESET    = 32'h0000_0000;
    localparam logic [31:0] GUARD_PSC_RESET    = 32'h0000_0000;
    localparam logic [31:0] MODE_CTRL_MASK     = 32'h0000_07FF;
    localparam logic [31:0] MODE_CTRL_RED_MASK = 32'h0000_00CF;
    localparam logic [31:0] GUARD_PSC_MASK     = 32'h0000_FFFF;
    localparam logic [31:0] GUARD_PSC_RED_MASK = 32'h0000_00FF;
    localparam int BIT_CTS_IRQ_EN   = 10;
    localparam int BIT_CTS_FLOW_EN  = 9;
    localparam int BIT_RTS_FLOW_EN  = 8;
    localparam int BIT_TX_DMA_EN    = 7;
    localparam int BIT_RX_DMA_EN    = 6;
    localparam int BIT_SMARTCARD_EN = 5;
    localparam int BIT_NACK_EN      = 4;
    localparam int BIT_HALF_DUPLEX  = 3;
    localparam int BIT_IR_LOW_POWER = 2;
    localparam int BIT_IR_EN        = 1;
    localparam int BIT_ERR_IRQ_EN   = 0;
    localparam int GUARD_LSB        = 8;
    localparam int PSC_LSB          = 0;
    localparam int SC_PSC_WIDTH     = 5;
    localparam logic [7:0] DIV_RESET = 8'h00;
endpackage

/* File: rtl/umc_clk_div.sv */
// Clock divider producing a one-cycle tick every div clk cycles.
// Assumes div is stable while enabled; a value of zero stops the tick.
`timescale 1ns/10ps
module umc_clk_div #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         enable,
    input  wire logic [W-1:0] div,
    output logic              tick
);
    import umc_pkg::*;
    logic [W-1:0] count_ff;
    logic [W-1:0] nxt_count;
    logic         nxt_tick;
    wire          atEnd = (count_ff + W'(1)) >= div;

    assign nxt_count = (!enable || div == '0 || atEnd) ? '0 : count_ff + W'(1);
    assign nxt_tick  = enable && (div != '0) && atEnd;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_ff <= '0;
            tick     <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            tick     <= nxt_tick;
        end
    end
endmodule

/* File: rtl/umc_mode_ctrl.sv */
// Mode control and guard-time/prescaler registers of a serial port.
// Assumes the core supplies status flags, baud ticks and a word register port.
// What this block does
// - CTS-change flag raises interrupt when its enable bit 10 is set
// - Bit 9 switches CTS hardware flow control
// - Bit 8 switches RTS hardware flow control
// - Bit 7 clear blocks every transmit DMA request
// - Bit 6 clear blocks every receive DMA request
// - Bit 5 selects smartcard operation
// - Smartcard parity error sends NACK only when bit 4 set
// - Bit 3 selects half-duplex operation
// - Bit 2 selects infrared low-power sub-mode
// - Bit 1 enables infrared encoding
// - With receive DMA, error flags interrupt when bit 0 set
// - Reduced variant ignores CTS, RTS, smartcard, NACK and guard fields
// - Smartcard completion flag delayed by guard-time baud cycles
// - Low-power infrared clock is peripheral clock over 8-bit prescaler
// - Smartcard clock divides by twice the low five prescaler bits
`timescale 1ns/10ps
module umc_mode_ctrl #(
    parameter bit REDUCED = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [7:0]  regAddr,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [31:0] regWdata,
    output logic [31:0]      regRdata,
    input  wire logic        ctsChangeFlag,
    input  wire logic        framingErrorFlag,
    input  wire logic        overrunErrorFlag,
    input  wire logic        noiseErrorFlag,
    input  wire logic        txBufferEmpty,
    input  wire logic        rxDataWaiting,
    input  wire logic        rxParityError,
    input  wire logic        txFrameDone,
    input  wire logic        baudTick,
    output logic             ctsIrq,
    output logic             errorIrq,
    output logic             txDmaReq,
    output logic             rxDmaReq,
    output logic             ctsFlowEn,
    output logic             rtsFlowEn,
    output logic             smartcardMode,
    output logic             halfDuplexMode,
    output logic             irEnable,
    output logic             irLowPower,
    output logic             sendNack,
    output logic             transmissionCompleteFlag,
    output logic             irLowPowerTick,
    output logic             smartcardClk
);
    import umc_pkg::*;

    // Guard sequencer, one-hot
    typedef enum logic [1:0] {
        GD_IDLE = 2'b01,
        GD_WAIT = 2'b10
    } umc_guard_state_t;

    logic [31:0] modeCtrl_ff;
    logic [31:0] guardPsc_ff;
    logic [7:0]  guardCount_ff;
    umc_guard_state_t guardState_ff;
    logic        ctsPrev_ff;
    logic        errPrev_ff;
    logic        scClk_ff;
    logic [7:0]  nxt_guardCount;
    umc_guard_state_t nxt_guardState;
    logic        nxt_tc;
    logic        scTick;
    logic        irTick;

    // Address decode; registers are word wide only
    wire         selMode     = regAddr == MODE_CTRL_OFFSET;
    wire         selGuard    = regAddr == GUARD_PSC_OFFSET;
    // Reduced variant masks unsupported fields
    wire [31:0]  modeMask    = REDUCED ? MODE_CTRL_RED_MASK : MODE_CTRL_MASK;
    wire [31:0]  guardMask   = REDUCED ? GUARD_PSC_RED_MASK : GUARD_PSC_MASK;
    wire [31:0]  rdMux       = selMode ? modeCtrl_ff : (selGuard ? guardPsc_ff : 32'h0000_0000);

    wire         ctsIrqEn    = modeCtrl_ff[BIT_CTS_IRQ_EN];
    wire         cts_flow_enable       = modeCtrl_ff[BIT_CTS_FLOW_EN];
    wire         rts_flow_enable       = modeCtrl_ff[BIT_RTS_FLOW_EN];
    wire         txDmaEn     = modeCtrl_ff[BIT_TX_DMA_EN];
    wire         rxDmaEn     = modeCtrl_ff[BIT_RX_DMA_EN];
    wire         smartcard_enable        = modeCtrl_ff[BIT_SMARTCARD_EN];
    wire         nackEn      = modeCtrl_ff[BIT_NACK_EN];
    wire         half_duplex_enable        = modeCtrl_ff[BIT_HALF_DUPLEX];
    wire         infrared_low_power        = modeCtrl_ff[BIT_IR_LOW_POWER];
    wire         infrared_enable        = modeCtrl_ff[BIT_IR_EN];
    wire         errIrqEn    = modeCtrl_ff[BIT_ERR_IRQ_EN];
    wire [7:0]   guardTime   = guardPsc_ff[GUARD_LSB +: 8];
    wire [7:0]   clockPsc    = guardPsc_ff[PSC_LSB +: 8];
    // Smartcard divider counts half periods of the card clock
    wire [7:0]   scPsc       = {3'b000, clockPsc[SC_PSC_WIDTH-1:0]};
    wire         anyError    = framingErrorFlag | overrunErrorFlag | noiseErrorFlag;
    wire         ctsRise     = ctsChangeFlag & ~ctsPrev_ff;
    wire         errRise     = anyError & ~errPrev_ff;

    wire         guardStart  = txFrameDone & smartcard_enable & (guardTime != 8'h00);
    wire         guardWaiting = guardState_ff == GD_WAIT;
    wire         guardExpire = guardWaiting & baudTick & (guardCount_ff <= 8'h01);

    always_comb begin
        nxt_guardCount = guardCount_ff;
        nxt_guardState = guardState_ff;
        nxt_tc         = 1'b0;
        unique case (guardState_ff)
            GD_IDLE: begin
                if (guardStart) begin
                    nxt_guardCount = guardTime;
                    nxt_guardState = GD_WAIT;
                end
            end
            GD_WAIT: begin
                if (guardStart) begin
                    // A new frame end restarts the guard interval
                    nxt_guardCount = guardTime;
                end else if (guardExpire) begin
                    nxt_guardCount = 8'h00;
                    nxt_guardState = GD_IDLE;
                    nxt_tc         = 1'b1;
                end else if (baudTick) begin
                    nxt_guardCount = guardCount_ff - 8'h01;
                end
            end
            default: begin
                nxt_guardCount = DIV_RESET;
                nxt_guardState = GD_IDLE;
            end
        endcase
        if (txFrameDone && !guardStart) begin
            nxt_tc = 1'b1;
        end
    end

    umc_clk_div #(
        .W (8)
    ) u_ir_div (
        .clk    (clk),
        .nrst   (nrst),
        .enable (infrared_enable & infrared_low_power),
        .div    (clockPsc),
        .tick   (irTick)
    );

    umc_clk_div #(
        .W (8)
    ) u_sc_div (
        .clk    (clk),
        .nrst   (nrst),
        .enable (smartcard_enable),
        .div    (scPsc),
        .tick   (scTick)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            modeCtrl_ff <= MODE_CTRL_RESET;
        end else if (regWrite && selMode) begin
            modeCtrl_ff <= regWdata & modeMask;
        end
    end

    // Guard field dropped on reduced variant
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            guardPsc_ff <= GUARD_PSC_RESET;
        end else if (regWrite && selGuard) begin
            guardPsc_ff <= regWdata & guardMask;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            regRdata <= 32'h0000_0000;
        end else begin
            regRdata <= regRead ? rdMux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            guardState_ff <= GD_IDLE;
        end else begin
            guardState_ff <= nxt_guardState;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            guardCount_ff <= DIV_RESET;
        end else begin
            guardCount_ff <= nxt_guardCount;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            transmissionCompleteFlag <= 1'b0;
        end else begin
            transmissionCompleteFlag <= nxt_tc;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctsPrev_ff <= 1'b0;
            ctsIrq     <= 1'b0;
        end else begin
            ctsPrev_ff <= ctsChangeFlag;
            ctsIrq     <= ctsRise & ctsIrqEn;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            errPrev_ff <= 1'b0;
            errorIrq   <= 1'b0;
        end else begin
            errPrev_ff <= anyError;
            errorIrq   <= errRise & errIrqEn & rxDmaEn;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            txDmaReq <= 1'b0;
        end else begin
            txDmaReq <= txDmaEn & txBufferEmpty;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rxDmaReq <= 1'b0;
        end else begin
            rxDmaReq <= rxDmaEn & rxDataWaiting;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctsFlowEn <= 1'b0;
        end else begin
            ctsFlowEn <= cts_flow_enable;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rtsFlowEn <= 1'b0;
        end else begin
            rtsFlowEn <= rts_flow_enable;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            smartcardMode <= 1'b0;
        end else begin
            smartcardMode <= smartcard_enable;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            halfDuplexMode <= 1'b0;
        end else begin
            halfDuplexMode <= half_duplex_enable;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irEnable <= 1'b0;
        end else begin
            irEnable <= infrared_enable;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irLowPower <= 1'b0;
        end else begin
            irLowPower <= infrared_low_power;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sendNack <= 1'b0;
        end else begin
            sendNack <= smartcard_enable & nackEn & rxParityError;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irLowPowerTick <= 1'b0;
        end else begin
            irLowPowerTick <= irTick;
        end
    end

    // Toggle per half period doubles the divide factor
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scClk_ff <= 1'b0;
        end else begin
            scClk_ff <= smartcard_enable ? (scClk_ff ^ scTick) : 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            smartcardClk <= 1'b0;
        end else begin
            smartcardClk <= scClk_ff;
        end
    end
endmodule

/* File: sim/umc_peer.sv */
// Far-side model: baud tick source and end-of-frame pulser.
// Assumes fire is raised for one clock per frame by the bench.
`timescale 1ns/10ps
module umc_peer (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic fire,
    output logic      baudTick,
    output logic      txFrameDone
);
    logic [1:0] cnt_ff;
    wire  [1:0] nxt_cnt = (fire || cnt_ff == 2'h2) ? 2'h0 : cnt_ff + 2'h1;
    // Ticks restart with each frame so none lands on the done cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff      <= 2'h0;
            baudTick    <= 1'b0;
            txFrameDone <= 1'b0;
        end else begin
            cnt_ff      <= nxt_cnt;
            baudTick    <= cnt_ff == 2'h2 && !fire;
            txFrameDone <= fire;
        end
    end
endmodule

/* File: sim/umc_props.sv */
// Checker for the mode control block, attached to its ports by bind.
// Assumes one clock domain and the full port variant.
`timescale 1ns/10ps
module umc_props
    import umc_pkg::*;
(
    input wire logic        clk, nrst, regWrite, regRead, ctsChangeFlag, txBufferEmpty,
    input wire logic        rxDataWaiting, txFrameDone, ctsIrq, txDmaReq, rxDmaReq,
    input wire logic        smartcardMode, sendNack, transmissionCompleteFlag, smartcardClk,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWdata, regRdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_wrrd;
        regWrite && regAddr == MODE_CTRL_OFFSET ##1 !regWrite
            ##1 regRead && !regWrite && regAddr == MODE_CTRL_OFFSET;
    endsequence
    property p_rdback; s_wrrd |=> regRdata == ($past(regWdata, 3) & MODE_CTRL_MASK); endproperty
    a_rdback: assert property (p_rdback) else $error("control readback wrong");
    property p_rdidle; !$past(regRead) |-> regRdata == 32'h0000_0000; endproperty
    a_rdidle: assert property (p_rdidle) else $error("read data outside read");
    property p_cts; ctsIrq |-> ($past(ctsChangeFlag) || $past(ctsChangeFlag, 2)) ##1 !ctsIrq; endproperty
    a_cts: assert property (p_cts) else $error("cts irq without flag change");
    property p_txdma; txDmaReq |-> $past(txBufferEmpty); endproperty
    a_txdma: assert property (p_txdma) else $error("tx dma without empty buffer");
    property p_rxdma; rxDmaReq |-> $past(rxDataWaiting); endproperty
    a_rxdma: assert property (p_rxdma) else $error("rx dma without data");
    property p_tc;
        txFrameDone && !smartcardMode && !$past(regWrite) |=> transmissionCompleteFlag;
    endproperty
    a_tc: assert property (p_tc) else $error("completion flag late");
    property p_scclk;
        !smartcardMode && !$past(smartcardMode) && !$past(regWrite) |-> !smartcardClk;
    endproperty
    a_scclk: assert property (p_scclk) else $error("card clock outside card mode");
    property p_nack; sendNack |-> smartcardMode; endproperty
    a_nack: assert property (p_nack) else $error("nack outside card mode");
endmodule
bind umc_mode_ctrl umc_props i_umc_props (.clk, .nrst, .regWrite, .regRead, .ctsChangeFlag,
    .txBufferEmpty, .rxDataWaiting, .txFrameDone, .ctsIrq, .txDmaReq, .rxDmaReq, .smartcardMode,
    .sendNack, .transmissionCompleteFlag, .smartcardClk, .regAddr, .regWdata, .regRdata);

/* File: sim/umc_mode_ctrl_test.sv */
// Self-checking bench for the mode control and prescaler block.
// Assumes the peer model supplies baud ticks and frame-done pulses.
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module umc_mode_ctrl_test;
    import umc_pkg::*;
    logic        clk, nrst, regWrite, regRead, fire, rdv, pe, tbe, rdw, baudTick, txFrameDone;
    logic        ctsIrq, errorIrq, txDmaReq, rxDmaReq, ctsFlowEn, rtsFlowEn, sendNack, tcf;
    logic        smartcardMode, halfDuplexMode, irEnable, irLowPower, irTick, scClk;
    logic [7:0]  regAddr;
    logic [31:0] regWdata, regRdata, d, ex, r;
    logic [3:0]  flg;
    logic [31:0] q[$];
    int          failures, checks_done, cyc, ci, ei, n, c;
    integer      seed = 50535;
    wire  [31:0] mv = {22'h00_0000, ctsFlowEn, rtsFlowEn, 2'h0, smartcardMode, 1'b0,
                       halfDuplexMode, irLowPower, irEnable, 1'b0};
    umc_mode_ctrl i_umc_mode_ctrl (.clk, .nrst, .regAddr, .regWrite, .regRead, .regWdata,
        .regRdata, .ctsChangeFlag(flg[3]), .framingErrorFlag(flg[2]), .overrunErrorFlag(flg[1]),
        .noiseErrorFlag(flg[0]), .txBufferEmpty(tbe), .rxDataWaiting(rdw), .rxParityError(pe),
        .txFrameDone, .baudTick, .ctsIrq, .errorIrq, .txDmaReq, .rxDmaReq, .ctsFlowEn,
        .rtsFlowEn, .smartcardMode, .halfDuplexMode, .irEnable, .irLowPower, .sendNack,
        .transmissionCompleteFlag(tcf), .irLowPowerTick(irTick), .smartcardClk(scClk));
    umc_peer i_umc_peer (.clk, .nrst, .fire, .baudTick, .txFrameDone);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge clk);
        #1 regAddr = a;
        regWdata = w;
        regWrite = 1'b1;
        @(posedge clk);
        #1 regWrite = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        #1 regAddr = a;
        regRead = 1'b1;
        q.push_back(e);
        @(posedge clk);
        #1 regRead = 1'b0;
    endtask
    // Counts baud ticks until completion shows, and cycles spent
    task automatic frame();
        n = 0;
        c = 0;
        @(posedge clk);
        #1 fire = 1'b1;
        @(posedge clk);
        #1 fire = 1'b0;
        while (c < 60) begin
            @(negedge clk);
            if (tcf === 1'b1) break;
            n += baudTick;
            c++;
        end
    endtask
    // Card clock rises into n, low-power ticks into c, over 24 cycles
    task automatic meas();
        logic p;
        n = 0;
        c = 0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        p = scClk;
        repeat (24) begin
            @(negedge clk);
            n += scClk & ~p;
            c += irTick;
            p = scClk;
        end
    endtask
    task end_sim();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk) begin
        rdv <= regRead;
        if (rdv === 1'b1) begin
            ex = q.pop_front();
            `CHK(regRdata, ex)
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        {nrst, regWrite, regRead, fire, pe, tbe, rdw} = 7'h00;
        regAddr = 8'h00;
        regWdata = 32'h0000_0000;
        flg = 4'h0;
        repeat (5) @(posedge clk);
        #1 nrst = 1'b1;
        rd(MODE_CTRL_OFFSET, MODE_CTRL_RESET);
        rd(GUARD_PSC_OFFSET, GUARD_PSC_RESET);
        for (int i = 0; i < 16; i++) begin
            d = (i < 11) ? 32'h0000_0001 << i : $random(seed);
            r = $random(seed);
            {pe, rdw, tbe} = r[2:0];
            wr(MODE_CTRL_OFFSET, d);
            rd(MODE_CTRL_OFFSET, d & MODE_CTRL_MASK);
            `CHK(mv, d & 32'h0000_032E)
            `CHK({txDmaReq, rxDmaReq, sendNack}, {d[7] & tbe, d[6] & rdw, d[5] & d[4] & pe})
        end
        wr(8'h1C, $random(seed));
        rd(8'h1C, 32'h0000_0000);
        rd(MODE_CTRL_OFFSET, d & MODE_CTRL_MASK);
        for (int k = 0; k < 8; k++) begin
            wr(MODE_CTRL_OFFSET, k[0] ? 32'h0000_0441 : 32'h0000_0001);
            ci = 0;
            ei = 0;
            flg = 4'h8 >> k[2:1];
            repeat (4) begin
                @(negedge clk);
                ci += ctsIrq;
                ei += errorIrq;
            end
            flg = 4'h0;
            `CHK({ci[1:0], ei[1:0]}, {1'b0, k[0] && k[2:1] == 0, 1'b0, k[0] && k[2:1] != 0})
        end
        d = $random(seed);
        wr(GUARD_PSC_OFFSET, d);
        rd(GUARD_PSC_OFFSET, d & GUARD_PSC_MASK);
        wr(MODE_CTRL_OFFSET, 32'h0000_0000);
        wr(GUARD_PSC_OFFSET, 32'h0000_0201);
        frame();
        `CHK(c, 1)
        wr(MODE_CTRL_OFFSET, 32'h0000_0020);
        frame();
        `CHK(n, 2)
        wr(GUARD_PSC_OFFSET, 32'h0000_00E2);
        meas();
        `CHK({n, c}, {32'h0000_0006, 32'h0000_0000})
        wr(MODE_CTRL_OFFSET, 32'h0000_0006);
        wr(GUARD_PSC_OFFSET, 32'h0000_0003);
        meas();
        `CHK({n, c}, {32'h0000_0000, 32'h0000_0008})
        wr(GUARD_PSC_OFFSET, 32'h0000_0001);
        wr(MODE_CTRL_OFFSET, 32'h0000_0002);
        meas();
        `CHK(c, 0)
        end_sim();
    end
endmodule
